/* logic/swd_pkg.sv */
package swd_pkg;

  // Host-side I/O port addresses of the configuration window.
  localparam logic [15:0] CFG_INDEX_ADDR  = 16'h002E;
  localparam logic [15:0] CFG_DATA_ADDR   = 16'h002F;

  localparam logic [7:0]  KEY_ENTER       = 8'h87;
  localparam logic [7:0]  KEY_EXIT        = 8'hAA;

  // Configuration register indexes.
  localparam logic [7:0]  IDX_DEVICE_SEL  = 8'h07;
  localparam logic [7:0]  IDX_PIN_ROUTE   = 8'h2B;
  localparam logic [7:0]  IDX_GPIO_DIR    = 8'hF0;
  localparam logic [7:0]  IDX_GPIO_LEVEL  = 8'hF1;
  localparam logic [7:0]  IDX_GPIO_INV    = 8'hF2;
  localparam logic [7:0]  IDX_COUNT_MODE  = 8'hF5;
  localparam logic [7:0]  IDX_TIMEOUT     = 8'hF6;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'hF7;

  localparam logic [7:0]  WDT_DEVICE      = 8'h08;

  // Field positions.
  localparam int          PIN_BIT         = 4;
  localparam int          ROUTE_BIT       = 4;
  localparam int          RES_MIN_BIT     = 3;
  localparam int          STATUS_BIT      = 4;
  localparam logic [3:0]  IRQ_SMI         = 4'h2;

  // Reset values and the answer to an unmapped read.
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [3:0]  IRQ_SEL_RESET   = 4'h0;
  localparam logic [7:0]  UNMAPPED_READ   = 8'hFF;

  // Timing.
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned UNIT_SECOND_S   = 1;
  localparam int unsigned SEC_CYCLES      = UNIT_SECOND_S * CLK_HZ;
  localparam int unsigned SECONDS_PER_MIN = 60;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } swd_io_req_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } swd_io_rsp_type;

  typedef struct packed {
    logic out;
    logic oe;
  } swd_pin_type;

  typedef enum logic [2:0] {
    CFG_LOCKED = 3'b001,
    CFG_KEY1   = 3'b010,
    CFG_OPEN   = 3'b100
  } swd_cfg_state_type;

endpackage : swd_pkg

/* logic/swd_watchdog_config.sv */
`timescale 1ns/1ps
// Behaviour
// - Two successive writes of 0x87 to port 0x2E unlock configuration mode.
// - One write of 0xAA to the enable port relocks configuration.
// - After relocking, a new entry key sequence is accepted at any time.
// - Index at 0x2E, data at 0x2F; data reaches register named by index.
// - Index 0x07 selects logical device; watchdog and GPIO port share device 0x08.
// - Global registers are reachable without selecting a logical device.
// - Host writes index then reads or writes data port.
// - Down counter programmable 1 to 255 units of a second or minute.
// - A non-zero time-out write reloads the counter and starts counting.
// - At zero the counter asserts reset output or the selected interrupt.
// - Bit 3 of watchdog_count_mode selects second or minute units.
// - Register watchdog_timeout_count holds the count; writing zero stops the watchdog.
// - Bit 4 of shared_pin_route routes shared pin to general pin or time-out output.
// - Low nibble of watchdog_irq_and_status selects interrupt line 0 to 15; 2 means SMI.
// - Bit 4 of watchdog_irq_and_status reads 1 after a time-out until a later write to watchdog_timeout_count.
// - Bit 4 of gpio_direction, gpio_output_level, gpio_inversion set pin direction, level and inversion.
module swd_watchdog_config
  import swd_pkg::*;
#(
  parameter int unsigned SEC_TICKS = SEC_CYCLES
) (
  input  wire logic           core_clk_i,
  input  wire logic           rst_i,
  input  wire swd_io_req_type io_req_i,
  output swd_io_rsp_type      io_rsp_o,
  input  wire logic           shared_general_pin_i,
  output swd_pin_type         shared_general_pin_o,
  output logic                sys_reset_o,
  output logic [15:0]         irq_o,
  output logic                smi_o
);

  localparam int PW = $clog2(SEC_TICKS);
  localparam logic [PW-1:0] PRESC_LAST = PW'(SEC_TICKS - 1);
  localparam logic [5:0]    MIN_LAST   = 6'(SECONDS_PER_MIN - 1);

  // The prescaler needs at least two states to separate one second tick from the next.
  if (SEC_TICKS < 2) begin : g_chk
    $error("SEC_TICKS must be at least 2");
  end

  // The status flag must not overlap the interrupt select field of the same byte.
  if ((STATUS_BIT < 4) || (STATUS_BIT > 7)) begin : g_chk_status
    $error("STATUS_BIT must lie between 4 and 7");
  end

  // The minute counter is six bits wide.
  if ((SECONDS_PER_MIN < 2) || (SECONDS_PER_MIN > 64)) begin : g_chk_minute
    $error("SECONDS_PER_MIN must lie between 2 and 64");
  end

  function automatic logic [7:0] set_bit4(input logic [7:0] v, input logic b);
    logic [7:0] r;
    r = v;
    r[PIN_BIT] = b;
    return r;
  endfunction : set_bit4

  // The index and enable port share one address; the data port sits one above it.
  function automatic logic is_index_port(input logic [15:0] a);
    return a == CFG_INDEX_ADDR;
  endfunction : is_index_port

  function automatic logic is_data_port(input logic [15:0] a);
    return a == CFG_DATA_ADDR;
  endfunction : is_data_port

  // The status flag sits above the interrupt select; the remaining bits read as zero.
  function automatic logic [7:0] irq_status_view(input logic s, input logic [3:0] sel);
    logic [7:0] r;
    r             = {4'h0, sel};
    r[STATUS_BIT] = s;
    return r;
  endfunction : irq_status_view

  // Configuration access state.
  swd_cfg_state_type state;
  swd_cfg_state_type next_state;
  logic [7:0]        index;
  logic [7:0]        next_index;
  logic [7:0]        dev_sel;
  logic [7:0]        next_dev_sel;
  logic [7:0]        pin_route;
  logic [7:0]        next_pin_route;
  logic [7:0]        gpio_dir;
  logic [7:0]        next_gpio_dir;
  logic [7:0]        gpio_level;
  logic [7:0]        next_gpio_level;
  logic [7:0]        gpio_inv;
  logic [7:0]        next_gpio_inv;
  logic [7:0]        count_mode;
  logic [7:0]        next_count_mode;
  logic [3:0]        irq_sel;
  logic [3:0]        next_irq_sel;
  swd_io_rsp_type    next_rsp;

  // Watchdog state.
  logic [7:0]        count;
  logic [7:0]        next_count;
  logic [PW-1:0]     presc;
  logic [PW-1:0]     next_presc;
  logic [5:0]        minute;
  logic [5:0]        next_minute;
  logic              status;
  logic              next_status;

  // Output state.
  swd_pin_type       next_pin;
  logic              next_sys_reset;
  logic [15:0]       next_irq;
  logic              next_smi;

  // Pin input synchroniser.
  logic              pin_meta;
  logic              pin_sync;

  // Decoded accesses and derived ticks.
  logic              wr_index;
  logic              wr_data;
  logic              wdt_dev;
  logic              wr_timeout;
  logic              route_gpio;
  logic              sec_tick;
  logic              unit_tick;
  logic [7:0]        level_view;
  logic [7:0]        reg_rdata;

  assign wr_index   = io_req_i.wr && is_index_port(io_req_i.addr);
  assign wr_data    = io_req_i.wr && is_data_port(io_req_i.addr);
  assign wdt_dev    = (dev_sel == WDT_DEVICE);
  // Only a write that reaches the count register while unlocked re-arms the counter.
  assign wr_timeout = wr_data && (state == CFG_OPEN) && wdt_dev && (index == IDX_TIMEOUT);
  assign route_gpio = pin_route[ROUTE_BIT];

  // An input pin reads back through the level register after inversion.
  assign level_view = gpio_dir[PIN_BIT] ?
                      set_bit4(gpio_level, pin_sync ^ gpio_inv[PIN_BIT]) : gpio_level;

  // Device registers answer only while the watchdog device is selected; global ones always.
  always_comb begin
    reg_rdata = UNMAPPED_READ;
    case (index)
      IDX_DEVICE_SEL: reg_rdata = dev_sel;
      IDX_PIN_ROUTE:  reg_rdata = pin_route;
      IDX_GPIO_DIR:   if (wdt_dev) reg_rdata = gpio_dir;
      IDX_GPIO_LEVEL: if (wdt_dev) reg_rdata = level_view;
      IDX_GPIO_INV:   if (wdt_dev) reg_rdata = gpio_inv;
      IDX_COUNT_MODE: if (wdt_dev) reg_rdata = count_mode;
      IDX_TIMEOUT:    if (wdt_dev) reg_rdata = count;
      IDX_IRQ_STATUS: if (wdt_dev) reg_rdata = irq_status_view(status, irq_sel);
      default:        reg_rdata = UNMAPPED_READ;
    endcase
  end

  // A read or data write between the two keys drops back to locked, so a broken key
  // sequence never leaves the window half open.
  always_comb begin
    next_state      = state;
    next_index      = index;
    next_dev_sel    = dev_sel;
    next_pin_route  = pin_route;
    next_gpio_dir   = gpio_dir;
    next_gpio_level = gpio_level;
    next_gpio_inv   = gpio_inv;
    next_count_mode = count_mode;
    next_irq_sel    = irq_sel;
    // Every read is answered one cycle later, even while locked, so the host never stalls.
    next_rsp.valid  = io_req_i.rd;
    next_rsp.data   = UNMAPPED_READ;
    case (state)
      CFG_LOCKED: begin
        // While locked, port accesses only feed the key detector.
        if (wr_index && (io_req_i.wdata == KEY_ENTER)) begin
          next_state = CFG_KEY1;
        end
      end
      CFG_KEY1: begin
        // Only a second key at the index port completes the entry.
        if (wr_index) begin
          next_state = (io_req_i.wdata == KEY_ENTER) ? CFG_OPEN : CFG_LOCKED;
        end else if (wr_data || io_req_i.rd) begin
          next_state = CFG_LOCKED;
        end
      end
      CFG_OPEN: begin
        if (io_req_i.rd) begin
          if (is_index_port(io_req_i.addr)) begin
            next_rsp.data = index;
          end else if (is_data_port(io_req_i.addr)) begin
            next_rsp.data = reg_rdata;
          end
        end
        // The exit key is never stored, so it can never name a register.
        if (wr_index) begin
          if (io_req_i.wdata == KEY_EXIT) begin
            next_state = CFG_LOCKED;
          end else begin
            next_index = io_req_i.wdata;
          end
        end else if (wr_data) begin
          case (index)
            IDX_DEVICE_SEL: next_dev_sel = io_req_i.wdata;
            IDX_PIN_ROUTE:  next_pin_route = io_req_i.wdata;
            IDX_GPIO_DIR:   if (wdt_dev) next_gpio_dir = io_req_i.wdata;
            IDX_GPIO_LEVEL: if (wdt_dev) next_gpio_level = io_req_i.wdata;
            IDX_GPIO_INV:   if (wdt_dev) next_gpio_inv = io_req_i.wdata;
            IDX_COUNT_MODE: if (wdt_dev) next_count_mode = io_req_i.wdata;
            // The status flag is read only; a write reaches the interrupt select alone.
            IDX_IRQ_STATUS: if (wdt_dev) next_irq_sel = io_req_i.wdata[3:0];
            default:        next_index = index;
          endcase
        end
      end
      default: next_state = CFG_LOCKED;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state      <= CFG_LOCKED;
      index      <= REG_RESET;
      dev_sel    <= REG_RESET;
      pin_route  <= REG_RESET;
      gpio_dir   <= REG_RESET;
      gpio_level <= REG_RESET;
      gpio_inv   <= REG_RESET;
      count_mode <= REG_RESET;
      irq_sel    <= IRQ_SEL_RESET;
      io_rsp_o   <= '0;
    end else begin
      state      <= next_state;
      index      <= next_index;
      dev_sel    <= next_dev_sel;
      pin_route  <= next_pin_route;
      gpio_dir   <= next_gpio_dir;
      gpio_level <= next_gpio_level;
      gpio_inv   <= next_gpio_inv;
      count_mode <= next_count_mode;
      irq_sel    <= next_irq_sel;
      io_rsp_o   <= next_rsp;
    end
  end

  // The prescaler runs only while the counter is armed.
  // The minute count keeps running in second units, so a live switch to minute units
  // may make the first minute short; software refreshes after changing the resolution.
  assign sec_tick  = (count != 8'h00) && (presc == PRESC_LAST);
  assign unit_tick = sec_tick && (!count_mode[RES_MIN_BIT] || (minute == MIN_LAST));

  always_comb begin
    next_count  = count;
    next_presc  = presc;
    next_minute = minute;
    // A refresh restarts the second and minute counts, so the full period follows it.
    if (wr_timeout) begin
      next_count  = io_req_i.wdata;
      next_presc  = '0;
      next_minute = '0;
    end else if (count != 8'h00) begin
      next_presc = sec_tick ? '0 : presc + 1'b1;
      if (sec_tick) begin
        next_minute = (minute == MIN_LAST) ? 6'h00 : minute + 6'h01;
      end
      if (unit_tick) begin
        next_count = count - 8'h01;
      end
    end
    // A time-out that lands on a refresh still sets the flag.
    next_status = (unit_tick && (count == 8'h01)) || (status && !wr_timeout);
  end

  // The count, prescaler and flag reset to a stopped, quiet watchdog.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count  <= REG_RESET;
      presc  <= '0;
      minute <= 6'h00;
      status <= 1'b0;
    end else begin
      count  <= next_count;
      presc  <= next_presc;
      minute <= next_minute;
      status <= next_status;
    end
  end

  // The time-out pin is active low and idles high, so a board reset line that it drives
  // stays released until the counter expires.
  always_comb begin
    next_sys_reset = status && !route_gpio;
    next_irq       = 16'h0000;
    next_smi       = 1'b0;
    if (status && route_gpio) begin
      // Line two carries the management interrupt instead when it is selected.
      if (irq_sel == IRQ_SMI) begin
        next_smi = 1'b1;
      end else begin
        next_irq = 16'h0001 << irq_sel;
      end
    end
    // In time-out mode the pin is always driven; otherwise it follows its direction bit.
    if (!route_gpio) begin
      next_pin.out = !status;
      next_pin.oe  = 1'b1;
    end else begin
      next_pin.out = gpio_level[PIN_BIT] ^ gpio_inv[PIN_BIT];
      next_pin.oe  = !gpio_dir[PIN_BIT];
    end
  end

  // Reset leaves the time-out pin released high and every action line low.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_o          <= 1'b0;
      irq_o                <= 16'h0000;
      smi_o                <= 1'b0;
      shared_general_pin_o <= '{out: 1'b1, oe: 1'b1};
    end else begin
      sys_reset_o          <= next_sys_reset;
      irq_o                <= next_irq;
      smi_o                <= next_smi;
      shared_general_pin_o <= next_pin;
    end
  end

  // Only the second stage is read, so a metastable first stage never reaches the logic.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= shared_general_pin_i;
      pin_sync <= pin_meta;
    end
  end

endmodule : swd_watchdog_config

/* bench/swd_watchdog_config_asserts.sv */
`timescale 1ns/1ps
module swd_watchdog_config_asserts
  import swd_pkg::*;
(
  input wire logic           core_clk_i,
  input wire logic           rst_i,
  input wire swd_io_req_type io_req_i,
  input wire swd_io_rsp_type io_rsp_o,
  input wire swd_pin_type    shared_general_pin_o,
  input wire logic           sys_reset_o,
  input wire logic [15:0]    irq_o,
  input wire logic           smi_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  a_read_answered: assert property (io_req_i.rd |=> io_rsp_o.valid)
    else $error("read not answered");
  a_no_stray_rsp: assert property (!io_req_i.rd |=> !io_rsp_o.valid)
    else $error("answer without read");
  a_one_action: assert property (sys_reset_o |-> !smi_o && irq_o == 16'h0000)
    else $error("reset and interrupt together");
  a_irq_single: assert property ($onehot0(irq_o))
    else $error("more than one interrupt line");
  a_smi_alone: assert property (smi_o |-> !irq_o[2])
    else $error("line two raised with smi");
  a_reset_pin: assert property (sys_reset_o |-> shared_general_pin_o.oe &&
    !shared_general_pin_o.out) else $error("time-out pin not driven low");
  a_action_holds: assert property (sys_reset_o && !io_req_i.wr &&
    !$past(io_req_i.wr) |=> sys_reset_o) else $error("reset output dropped");
  a_fall_by_write: assert property ($fell(sys_reset_o || smi_o || irq_o != 16'h0000)
    |-> $past(io_req_i.wr, 2)) else $error("action cleared without a write");
endmodule : swd_watchdog_config_asserts
bind swd_watchdog_config swd_watchdog_config_asserts u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .io_req_i(io_req_i), .io_rsp_o(io_rsp_o),
  .shared_general_pin_o(shared_general_pin_o), .sys_reset_o(sys_reset_o),
  .irq_o(irq_o), .smi_o(smi_o));

/* bench/swd_host_model.sv */
`timescale 1ns/1ps
module swd_host_model
  import swd_pkg::*;
(
  input  wire logic           core_clk_i,
  input  wire swd_io_rsp_type io_rsp_i,
  output swd_io_req_type      io_req_o
);
  logic [7:0] last_rd;
  initial io_req_o = '{1'b0, 1'b0, 16'hFFFF, 8'hFF};
  // One access, then an idle cycle that drives the inverse of address and data.
  task automatic acc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    io_req_o = '{w, r, a, d};
    @(posedge core_clk_i);
    #1;
    if (r) last_rd = io_rsp_i.valid ? io_rsp_i.data : 8'hXX;
    io_req_o = '{1'b0, 1'b0, ~a, ~d};
    @(posedge core_clk_i);
    #1;
  endtask : acc
  task automatic enter();
    acc(1'b1, 1'b0, CFG_INDEX_ADDR, KEY_ENTER);
    acc(1'b1, 1'b0, CFG_INDEX_ADDR, KEY_ENTER);
  endtask : enter
  task automatic leave();
    acc(1'b1, 1'b0, CFG_INDEX_ADDR, KEY_EXIT);
  endtask : leave
  task automatic set_reg(input logic [7:0] i, input logic [7:0] d);
    acc(1'b1, 1'b0, CFG_INDEX_ADDR, i);
    acc(1'b1, 1'b0, CFG_DATA_ADDR, d);
  endtask : set_reg
  task automatic get_reg(input logic [7:0] i);
    acc(1'b1, 1'b0, CFG_INDEX_ADDR, i);
    acc(1'b0, 1'b1, CFG_DATA_ADDR, 8'h00);
  endtask : get_reg
  task automatic select_wdt();
    set_reg(IDX_DEVICE_SEL, WDT_DEVICE);
  endtask : select_wdt
endmodule : swd_host_model

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench
  import swd_pkg::*;
;
  localparam int unsigned TICKS = 4;
  logic           core_clk_i = 1'b0;
  logic           rst_i      = 1'b1;
  swd_io_req_type io_req;
  swd_io_rsp_type io_rsp;
  swd_pin_type    pin_o;
  logic           sys_reset;
  logic [15:0]    irq;
  logic           smi;
  int             fail_count = 0;
  int             cmp_count  = 0;
  int             cycles     = 0;
  // The shared pin has a pull-up when nobody drives it.
  wire            pin_lvl = pin_o.oe ? pin_o.out : 1'b1;
  wire [17:0]     act     = {sys_reset, smi, irq};
  always #12.5 core_clk_i = ~core_clk_i;
  swd_host_model host (.core_clk_i(core_clk_i), .io_rsp_i(io_rsp), .io_req_o(io_req));
  swd_watchdog_config #(.SEC_TICKS(TICKS)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .io_req_i(io_req), .io_rsp_o(io_rsp),
    .shared_general_pin_i(pin_lvl), .shared_general_pin_o(pin_o),
    .sys_reset_o(sys_reset), .irq_o(irq), .smi_o(smi));
  task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rg(input logic [7:0] i, input logic [7:0] e);
    host.get_reg(i);
    chk("config read", 18'(host.last_rd), 18'(e));
  endtask : rg
  task automatic expire(input int n, input logic [17:0] e);
    repeat (n - 1) @(posedge core_clk_i);
    #1;
    chk("early action", act, 18'h0);
    @(posedge core_clk_i);
    #1;
    chk("action", act, e);
  endtask : expire
  task automatic t_locked();
    rg(IDX_DEVICE_SEL, UNMAPPED_READ);
    host.acc(1'b1, 1'b0, CFG_INDEX_ADDR, KEY_ENTER);
    host.acc(1'b1, 1'b0, CFG_DATA_ADDR, KEY_ENTER);
    host.acc(1'b1, 1'b0, CFG_INDEX_ADDR, KEY_ENTER);
    rg(IDX_DEVICE_SEL, UNMAPPED_READ);
  endtask : t_locked
  task automatic t_regs();
    logic [7:0] idx [4] = '{IDX_GPIO_DIR, IDX_GPIO_LEVEL, IDX_GPIO_INV, IDX_COUNT_MODE};
    host.enter();
    rg(IDX_DEVICE_SEL, REG_RESET);
    host.select_wdt();
    foreach (idx[k]) begin
      rg(idx[k], REG_RESET);
      host.set_reg(idx[k], 8'h6A);
      rg(idx[k], 8'h6A);
    end
    rg(IDX_TIMEOUT, REG_RESET);
    host.set_reg(IDX_IRQ_STATUS, 8'hFF);
    rg(IDX_IRQ_STATUS, 8'h0F);
    rg(8'h30, UNMAPPED_READ);
    host.acc(1'b0, 1'b1, CFG_INDEX_ADDR, 8'h00);
    chk("index read", 18'(host.last_rd), 18'h30);
    host.set_reg(IDX_DEVICE_SEL, 8'h03);
    rg(IDX_GPIO_DIR, UNMAPPED_READ);
    host.set_reg(IDX_PIN_ROUTE, 8'h10);
    rg(IDX_PIN_ROUTE, 8'h10);
    host.select_wdt();
  endtask : t_regs
  task automatic t_reset_act();
    host.set_reg(IDX_GPIO_DIR, 8'h00);
    host.set_reg(IDX_GPIO_LEVEL, 8'h00);
    host.set_reg(IDX_GPIO_INV, 8'h00);
    host.set_reg(IDX_PIN_ROUTE, 8'h00);
    host.set_reg(IDX_COUNT_MODE, 8'h00);
    host.set_reg(IDX_IRQ_STATUS, 8'h00);
    host.set_reg(IDX_TIMEOUT, 8'h02);
    expire(2 * TICKS, 18'h20000);
    chk("pin", 18'({pin_o.oe, pin_o.out}), 18'h2);
    rg(IDX_IRQ_STATUS, 8'h10);
    host.set_reg(IDX_TIMEOUT, 8'h00);
    chk("stopped", act, 18'h0);
    rg(IDX_IRQ_STATUS, 8'h00);
    host.set_reg(IDX_TIMEOUT, 8'h03);
    rg(IDX_IRQ_STATUS, 8'h00);
    repeat (2) @(posedge core_clk_i);
    #1;
    host.set_reg(IDX_TIMEOUT, 8'h03);
    expire(3 * TICKS, 18'h20000);
    host.set_reg(IDX_TIMEOUT, 8'h00);
  endtask : t_reset_act
  task automatic t_irq_act();
    logic [3:0]  sel [4] = '{4'h5, IRQ_SMI, 4'hF, 4'h0};
    logic [17:0] e;
    host.set_reg(IDX_PIN_ROUTE, 8'h10);
    host.set_reg(IDX_GPIO_LEVEL, 8'h10);
    chk("pin", 18'({pin_o.oe, pin_o.out}), 18'h3);
    host.set_reg(IDX_GPIO_INV, 8'h10);
    chk("pin", 18'({pin_o.oe, pin_o.out}), 18'h2);
    host.set_reg(IDX_GPIO_DIR, 8'h10);
    chk("pin", 18'({pin_o.oe, pin_o.out}), 18'h0);
    rg(IDX_GPIO_LEVEL, 8'h00);
    foreach (sel[k]) begin
      e = (sel[k] == IRQ_SMI) ? 18'h10000 : 18'(16'h1 << sel[k]);
      host.set_reg(IDX_IRQ_STATUS, {4'h0, sel[k]});
      host.set_reg(IDX_TIMEOUT, 8'h01);
      expire(TICKS, e);
      rg(IDX_IRQ_STATUS, {4'h1, sel[k]});
      host.set_reg(IDX_TIMEOUT, 8'h00);
    end
  endtask : t_irq_act
  task automatic t_minute();
    host.set_reg(IDX_PIN_ROUTE, 8'h00);
    host.set_reg(IDX_COUNT_MODE, 8'h08);
    host.set_reg(IDX_TIMEOUT, 8'h01);
    expire(SECONDS_PER_MIN * TICKS, 18'h20000);
    host.set_reg(IDX_TIMEOUT, 8'h00);
    host.leave();
    rg(IDX_DEVICE_SEL, UNMAPPED_READ);
    host.enter();
    rg(IDX_DEVICE_SEL, WDT_DEVICE);
  endtask : t_minute
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    t_locked();
    t_regs();
    t_reset_act();
    t_irq_act();
    t_minute();
    report_and_stop();
  end
endmodule : testbench
